// File: logic/lcd_cfg_map.vh
// Register offsets, command patterns, reset values and timing counts of the display configuration block.
`ifndef LCD_CFG_MAP_VH
`define LCD_CFG_MAP_VH

// APB byte offsets.
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_TEMP 8'h08
`define OFS_COMP 8'h0C

// Status register field positions.
`define ST_PTR_LSB 0
`define ST_FREQ_LSB 6
`define ST_DBANK 11
`define ST_WBANK 12
`define ST_OSC 13
`define ST_COE 14
`define ST_CPC 15
`define ST_CPE 16
`define ST_TCE 17
`define ST_TME 18
`define ST_TFE 19
`define ST_INV 20
`define ST_BIAS_LSB 21
`define ST_MUX_LSB 23
`define ST_DISP 26
`define ST_INIT 27
`define ST_READY 28

// Compensation register field positions.
`define CP_VPR_LSB 0
`define CP_SLA_LSB 8
`define CP_SLB_LSB 11
`define CP_SLC_LSB 14
`define CP_SLD_LSB 17

// Command patterns and the masks that pick their fixed bits.
`define CMD_OSC_MASK 8'hFC
`define CMD_OSC_VAL 8'hCC
`define CMD_PUMP_MASK 8'hFC
`define CMD_PUMP_VAL 8'hC0
`define CMD_TMSR_MASK 8'hFC
`define CMD_TMSR_VAL 8'hC8
`define CMD_BIAS_MASK 8'hFC
`define CMD_BIAS_VAL 8'hC4
`define CMD_INV_MASK 8'hFD
`define CMD_INV_VAL 8'hD4
`define CMD_TFILT_MASK 8'hFE
`define CMD_TFILT_VAL 8'hD2
`define CMD_SLOPE_MASK 8'hF8
`define CMD_SLA_VAL 8'h18
`define CMD_SLB_VAL 8'h20
`define CMD_SLC_VAL 8'h28
`define CMD_SLD_VAL 8'h30
`define CMD_VPR_MASK 8'hF0
`define CMD_VPRH_VAL 8'h40
`define CMD_VPRL_VAL 8'h50
`define CMD_DISP_MASK 8'hFE
`define CMD_DISP_VAL 8'h38
`define CMD_MUX_MASK 8'hF8
`define CMD_MUX_VAL 8'h00
`define CMD_PTR_MASK 8'hC0
`define CMD_PTR_VAL 8'h80
`define CMD_FREQ_MASK 8'hE0
`define CMD_FREQ_VAL 8'h60
`define CMD_BANK_MASK 8'hFC
`define CMD_BANK_VAL 8'h08
`define CMD_INIT_FIRST 8'h3A
`define CMD_INIT_SECOND 8'h3B

// Reset values and mux mode codes.
`define RST_MUX 3'h4
`define RST_BIAS 2'h0
`define RST_SLOPE 3'h0
`define RST_VPR_NIBBLE 4'h0
`define RST_FREQ 5'h0E
`define RST_PTR 6'h00
`define MUX_STATIC 3'h1
`define MUX_TWO 3'h2

// Timing.
`define CLK_MHZ 50
`define QUIET_TIME_US 1000
`define QUIET_CYCLES (`QUIET_TIME_US * `CLK_MHZ)
`define LINE_CYCLES 1000
`define TEMP_SAMPLE_CYCLES 2000
`define CLKOUT_HALF_CYCLES 2604

`endif

// File: logic/temp_filter.v
// Digital temperature filter that either passes the raw code or a running average.
`timescale 1ns/1ps
`include "lcd_cfg_map.vh"

module temp_filter #(
  parameter WIDTH = 8,
  parameter SHIFT = 2
) (
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // Raw samples.
  input wire sample_valid,
  input wire [WIDTH-1:0] raw_code,
  input wire filter_enable,
  // Result.
  output reg [WIDTH-1:0] code_out
);

  reg [WIDTH+SHIFT-1:0] acc_reg;
  reg [WIDTH+SHIFT-1:0] acc_next;
  wire [WIDTH+SHIFT-1:0] raw_wide;
  wire [WIDTH+SHIFT-1:0] acc_avg;

  assign raw_wide = {{SHIFT{1'b0}}, raw_code};
  assign acc_avg = acc_reg >> SHIFT;

  // The accumulator holds SHIFT fractional bits; each sample moves it a 2**-SHIFT step toward the input.
  always @* begin
    acc_next = acc_reg;
    if (sample_valid) begin
      if (filter_enable) begin
        acc_next = acc_reg - acc_avg + raw_wide;
      end else begin
        acc_next = raw_wide << SHIFT;
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_reg <= {(WIDTH+SHIFT){1'b0}};
      code_out <= {WIDTH{1'b0}};
    end else begin
      acc_reg <= acc_next;
      if (sample_valid) begin
        if (filter_enable) begin
          code_out <= acc_next[WIDTH+SHIFT-1:SHIFT];
        end else begin
          code_out <= raw_code;
        end
      end
    end
  end

endmodule // temp_filter

// File: logic/lcd_driver_config_commands.v
// Command interpreter holding the display driver configuration, reached over APB.
//
// Summary of operation
// - A temperature readout returns one 8-bit code from the internal sensor.
// - Inversion command is 110101 in bits 7..2, selector in bit 1, bit 0 zero.
// - Selector 0 (default) inverts per line; selector 1 inverts on alternate frames.
// - Frame inversion cancels DC over two consecutive frames.
// - Filter command is 1101001 in bits 7..1, enable in bit 0.
// - Filter off (default) uses the raw code at once; on applies filtering.
// - After reset or initialize, outputs grounded and display disabled.
// - After reset or initialize, four backplanes with quarter bias (mux 100, bias 00).
// - After reset or initialize, both bank selectors cleared and serial interfaces restarted.
// - After reset or initialize, oscillator runs, clock output off, clock pin undriven.
// - After reset or initialize, measurement and compensation on, filter off.
// - After reset or initialize, charge pump off and multiplier setting cleared.
// - Defaults: slopes 000, voltage nibbles 0000, frame frequency 01110.
// - The reset pin restores configuration but leaves display memory untouched.
`timescale 1ns/1ps
`include "lcd_cfg_map.vh"

module lcd_driver_config_commands #(
  parameter QUIET_CYCLES = `QUIET_CYCLES,
  parameter LINE_CYCLES = `LINE_CYCLES,
  parameter TEMP_SAMPLE_CYCLES = `TEMP_SAMPLE_CYCLES,
  parameter CLKOUT_HALF_CYCLES = `CLKOUT_HALF_CYCLES,
  parameter FILTER_SHIFT = 2
) (
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Temperature sensor.
  input wire [7:0] sensor_code,
  // Configuration seen by the analog and waveform logic.
  output reg display_enable,
  output reg outputs_grounded,
  output reg [2:0] mux_mode,
  output reg [1:0] bias_mode,
  output reg write_bank_select,
  output reg display_bank_select,
  output reg [5:0] data_pointer,
  output reg [4:0] frame_freq,
  output reg inversion_select,
  output reg drive_polarity,
  output reg temp_measure_enable,
  output reg temp_comp_enable,
  output reg temp_filter_enable,
  output reg pump_enable,
  output reg pump_multiplier_cfg,
  output reg [2:0] slope_region_a,
  output reg [2:0] slope_region_b,
  output reg [2:0] slope_region_c,
  output reg [2:0] slope_region_d,
  output reg [7:0] programmed_voltage,
  output reg oscillator_select,
  output reg internal_osc_run,
  output reg serial_if_restart,
  // Clock pin.
  output reg clock_pin_out,
  output reg clock_output_enable
);

  wire [31:0] quiet_load;
  wire [31:0] line_load;
  wire [31:0] sample_load;
  wire [31:0] clkout_load;
  reg [31:0] quiet_cnt_reg;
  reg [31:0] line_cnt_reg;
  reg [31:0] sample_cnt_reg;
  reg [31:0] clkout_cnt_reg;
  reg [1:0] line_idx_reg;
  reg [1:0] last_line;
  reg init_pending_reg;
  reg initialized_reg;
  reg ready_reg;
  reg sample_tick_reg;
  reg [7:0] sensor_reg;
  wire [7:0] temperature_code;
  wire access_write;
  wire setup_phase;
  wire cmd_strobe;
  wire [7:0] cmd_byte;
  wire init_cmd;
  wire line_tick;
  wire frame_end;
  wire coe_drop;
  reg [31:0] read_mux;
  reg read_err;

  assign quiet_load = QUIET_CYCLES - 1;
  assign line_load = LINE_CYCLES - 1;
  assign sample_load = TEMP_SAMPLE_CYCLES - 1;
  assign clkout_load = CLKOUT_HALF_CYCLES - 1;

  // APB: the answer is prepared in the setup cycle so pready and prdata come from flops.
  assign setup_phase = psel & ~penable;
  assign access_write = psel & penable & pready & pwrite;
  assign cmd_byte = pwdata[7:0];
  // A command byte counts only when the full write to the command register completes.
  assign cmd_strobe = access_write & (paddr == `OFS_CMD) & ready_reg;
  // The second initialize byte only takes effect right after the first one.
  assign init_cmd = cmd_strobe & init_pending_reg & (cmd_byte == `CMD_INIT_SECOND);
  assign coe_drop = init_cmd | (cmd_strobe & ((cmd_byte & `CMD_OSC_MASK) == `CMD_OSC_VAL) & ~cmd_byte[1]);

  always @* begin
    read_mux = 32'h00000000;
    read_err = 1'b0;
    case (paddr)
      `OFS_CMD: begin
        read_mux = 32'h00000000;
      end
      `OFS_STATUS: begin
        read_mux[`ST_PTR_LSB +: 6] = data_pointer;
        read_mux[`ST_FREQ_LSB +: 5] = frame_freq;
        read_mux[`ST_DBANK] = display_bank_select;
        read_mux[`ST_WBANK] = write_bank_select;
        read_mux[`ST_OSC] = oscillator_select;
        read_mux[`ST_COE] = clock_output_enable;
        read_mux[`ST_CPC] = pump_multiplier_cfg;
        read_mux[`ST_CPE] = pump_enable;
        read_mux[`ST_TCE] = temp_comp_enable;
        read_mux[`ST_TME] = temp_measure_enable;
        read_mux[`ST_TFE] = temp_filter_enable;
        read_mux[`ST_INV] = inversion_select;
        read_mux[`ST_BIAS_LSB +: 2] = bias_mode;
        read_mux[`ST_MUX_LSB +: 3] = mux_mode;
        read_mux[`ST_DISP] = display_enable;
        read_mux[`ST_INIT] = initialized_reg;
        read_mux[`ST_READY] = ready_reg;
      end
      `OFS_TEMP: begin
        read_mux[7:0] = temperature_code;
        read_err = pwrite;
      end
      `OFS_COMP: begin
        read_mux[`CP_VPR_LSB +: 8] = programmed_voltage;
        read_mux[`CP_SLA_LSB +: 3] = slope_region_a;
        read_mux[`CP_SLB_LSB +: 3] = slope_region_b;
        read_mux[`CP_SLC_LSB +: 3] = slope_region_c;
        read_mux[`CP_SLD_LSB +: 3] = slope_region_d;
        read_err = pwrite;
      end
      default: begin
        read_err = 1'b1;
      end
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        prdata <= pwrite ? 32'h00000000 : read_mux;
        pslverr <= read_err | (pwrite & (paddr == `OFS_STATUS));
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Commands are held off until the reset action has had time to complete.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      quiet_cnt_reg <= 32'h00000000;
      ready_reg <= 1'b0;
    end else if (!ready_reg) begin
      if (quiet_cnt_reg == quiet_load) begin
        ready_reg <= 1'b1;
      end else begin
        quiet_cnt_reg <= quiet_cnt_reg + 32'h00000001;
      end
    end
  end

  // Configuration fields; reset and the initialize command restore the same state.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      init_pending_reg <= 1'b0;
      initialized_reg <= 1'b0;
      serial_if_restart <= 1'b1;
      display_enable <= 1'b0;
      outputs_grounded <= 1'b1;
      mux_mode <= `RST_MUX;
      bias_mode <= `RST_BIAS;
      write_bank_select <= 1'b0;
      display_bank_select <= 1'b0;
      data_pointer <= `RST_PTR;
      frame_freq <= `RST_FREQ;
      inversion_select <= 1'b0;
      temp_measure_enable <= 1'b1;
      temp_comp_enable <= 1'b1;
      temp_filter_enable <= 1'b0;
      pump_enable <= 1'b0;
      pump_multiplier_cfg <= 1'b0;
      slope_region_a <= `RST_SLOPE;
      slope_region_b <= `RST_SLOPE;
      slope_region_c <= `RST_SLOPE;
      slope_region_d <= `RST_SLOPE;
      programmed_voltage <= {`RST_VPR_NIBBLE, `RST_VPR_NIBBLE};
      oscillator_select <= 1'b0;
      internal_osc_run <= 1'b1;
      clock_output_enable <= 1'b0;
    end else begin
      serial_if_restart <= 1'b0;
      if (cmd_strobe) begin
        init_pending_reg <= (cmd_byte == `CMD_INIT_FIRST);
      end
      if (init_cmd) begin
        initialized_reg <= 1'b1;
        serial_if_restart <= 1'b1;
        display_enable <= 1'b0;
        outputs_grounded <= 1'b1;
        mux_mode <= `RST_MUX;
        bias_mode <= `RST_BIAS;
        write_bank_select <= 1'b0;
        display_bank_select <= 1'b0;
        data_pointer <= `RST_PTR;
        frame_freq <= `RST_FREQ;
        inversion_select <= 1'b0;
        temp_measure_enable <= 1'b1;
        temp_comp_enable <= 1'b1;
        temp_filter_enable <= 1'b0;
        pump_enable <= 1'b0;
        pump_multiplier_cfg <= 1'b0;
        slope_region_a <= `RST_SLOPE;
        slope_region_b <= `RST_SLOPE;
        slope_region_c <= `RST_SLOPE;
        slope_region_d <= `RST_SLOPE;
        programmed_voltage <= {`RST_VPR_NIBBLE, `RST_VPR_NIBBLE};
        oscillator_select <= 1'b0;
        internal_osc_run <= 1'b1;
        clock_output_enable <= 1'b0;
      end else if (cmd_strobe) begin
        if ((cmd_byte & `CMD_INV_MASK) == `CMD_INV_VAL) begin
          inversion_select <= cmd_byte[1];
        end
        if ((cmd_byte & `CMD_TFILT_MASK) == `CMD_TFILT_VAL) begin
          temp_filter_enable <= cmd_byte[0];
        end
        if ((cmd_byte & `CMD_OSC_MASK) == `CMD_OSC_VAL) begin
          clock_output_enable <= cmd_byte[1];
          oscillator_select <= cmd_byte[0];
          internal_osc_run <= ~cmd_byte[0];
        end
        if ((cmd_byte & `CMD_PUMP_MASK) == `CMD_PUMP_VAL) begin
          pump_enable <= cmd_byte[1];
          pump_multiplier_cfg <= cmd_byte[0];
        end
        if ((cmd_byte & `CMD_TMSR_MASK) == `CMD_TMSR_VAL) begin
          temp_comp_enable <= cmd_byte[1];
          temp_measure_enable <= cmd_byte[0];
        end
        if ((cmd_byte & `CMD_BIAS_MASK) == `CMD_BIAS_VAL) begin
          bias_mode <= cmd_byte[1:0];
        end
        if ((cmd_byte & `CMD_SLOPE_MASK) == `CMD_SLA_VAL) begin
          slope_region_a <= cmd_byte[2:0];
        end
        if ((cmd_byte & `CMD_SLOPE_MASK) == `CMD_SLB_VAL) begin
          slope_region_b <= cmd_byte[2:0];
        end
        if ((cmd_byte & `CMD_SLOPE_MASK) == `CMD_SLC_VAL) begin
          slope_region_c <= cmd_byte[2:0];
        end
        if ((cmd_byte & `CMD_SLOPE_MASK) == `CMD_SLD_VAL) begin
          slope_region_d <= cmd_byte[2:0];
        end
        if ((cmd_byte & `CMD_VPR_MASK) == `CMD_VPRH_VAL) begin
          programmed_voltage[7:4] <= cmd_byte[3:0];
        end
        if ((cmd_byte & `CMD_VPR_MASK) == `CMD_VPRL_VAL) begin
          programmed_voltage[3:0] <= cmd_byte[3:0];
        end
        if ((cmd_byte & `CMD_DISP_MASK) == `CMD_DISP_VAL) begin
          display_enable <= cmd_byte[0];
          outputs_grounded <= ~cmd_byte[0];
        end
        if ((cmd_byte & `CMD_MUX_MASK) == `CMD_MUX_VAL) begin
          mux_mode <= cmd_byte[2:0];
        end
        if ((cmd_byte & `CMD_PTR_MASK) == `CMD_PTR_VAL) begin
          data_pointer <= cmd_byte[5:0];
        end
        if ((cmd_byte & `CMD_FREQ_MASK) == `CMD_FREQ_VAL) begin
          frame_freq <= cmd_byte[4:0];
        end
        if ((cmd_byte & `CMD_BANK_MASK) == `CMD_BANK_VAL) begin
          write_bank_select <= cmd_byte[1];
          display_bank_select <= cmd_byte[0];
        end
      end
    end
  end

  // Line timing; a frame holds one line in static mode, two in two-backplane mode and four in every other mux mode.
  always @* begin
    case (mux_mode)
      `MUX_STATIC: begin
        last_line = 2'd0;
      end
      `MUX_TWO: begin
        last_line = 2'd1;
      end
      default: begin
        last_line = 2'd3;
      end
    endcase
  end

  assign line_tick = (line_cnt_reg == line_load);
  assign frame_end = line_tick & (line_idx_reg >= last_line);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      line_cnt_reg <= 32'h00000000;
      line_idx_reg <= 2'd0;
      drive_polarity <= 1'b0;
    end else if (!display_enable) begin
      line_cnt_reg <= 32'h00000000;
      line_idx_reg <= 2'd0;
      drive_polarity <= 1'b0;
    end else begin
      line_cnt_reg <= line_tick ? 32'h00000000 : line_cnt_reg + 32'h00000001;
      if (line_tick) begin
        line_idx_reg <= frame_end ? 2'd0 : line_idx_reg + 2'd1;
      end
      if (inversion_select) begin
        // Polarity holds for a whole frame, so the DC balance closes over a frame pair.
        if (frame_end) begin
          drive_polarity <= ~drive_polarity;
        end
      end else if (line_tick) begin
        drive_polarity <= ~drive_polarity;
      end
    end
  end

  // Clock pin: driven with a divided clock only while the output is enabled.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      clkout_cnt_reg <= 32'h00000000;
      clock_pin_out <= 1'b0;
    end else if (!clock_output_enable || coe_drop) begin
      clkout_cnt_reg <= 32'h00000000;
      clock_pin_out <= 1'b0;
    end else if (clkout_cnt_reg == clkout_load) begin
      clkout_cnt_reg <= 32'h00000000;
      clock_pin_out <= ~clock_pin_out;
    end else begin
      clkout_cnt_reg <= clkout_cnt_reg + 32'h00000001;
    end
  end

  // Temperature sampling while measurement is enabled.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sample_cnt_reg <= 32'h00000000;
      sample_tick_reg <= 1'b0;
      sensor_reg <= 8'h00;
    end else begin
      sample_tick_reg <= 1'b0;
      if (temp_measure_enable) begin
        if (sample_cnt_reg == sample_load) begin
          sample_cnt_reg <= 32'h00000000;
          sample_tick_reg <= 1'b1;
          sensor_reg <= sensor_code;
        end else begin
          sample_cnt_reg <= sample_cnt_reg + 32'h00000001;
        end
      end
    end
  end

  temp_filter #(
    .WIDTH(8),
    .SHIFT(FILTER_SHIFT)
  ) filter_inst (
    .mclk(mclk),
    .rst(rst),
    .sample_valid(sample_tick_reg),
    .raw_code(sensor_reg),
    .filter_enable(temp_filter_enable),
    .code_out(temperature_code)
  );

endmodule // lcd_driver_config_commands

// File: bench/host_model.sv
// Host controller model that issues APB transfers to the configuration block.
`timescale 1ns/1ps
module host_model (
  // Clock.
  input wire logic mclk,
  // APB requests.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // APB answers.
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // One transfer; it starts on the next edge, so calls never collide in one time step.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // host_model

// File: bench/lcd_cfg_asserts.sv
// Concurrent checks on the ports of the display configuration command block.
`timescale 1ns/1ps
`include "lcd_cfg_map.vh"
module lcd_cfg_asserts #(
  parameter int QUIET_CYCLES = 20,
  parameter int LINE_CYCLES = 4
) (
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // APB.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // Configuration.
  input wire display_enable,
  input wire outputs_grounded,
  input wire [2:0] mux_mode,
  input wire [1:0] bias_mode,
  input wire write_bank_select,
  input wire display_bank_select,
  input wire inversion_select,
  input wire drive_polarity,
  input wire temp_measure_enable,
  input wire temp_filter_enable,
  input wire pump_enable,
  input wire oscillator_select,
  input wire internal_osc_run,
  input wire serial_if_restart,
  input wire clock_pin_out,
  input wire clock_output_enable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Commands only count once the quiet window is surely over.
  int unsigned up_cnt;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      up_cnt <= 0;
    end else if (up_cnt < QUIET_CYCLES + 4) begin
      up_cnt <= up_cnt + 1;
    end
  end
  wire live = up_cnt >= QUIET_CYCLES + 2;
  wire cmd_wr = psel && penable && pready && pwrite && paddr == `OFS_CMD;

  zero_wait_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready is not a single cycle after setup");
  err_resp_a: assert property (psel && penable && pready && paddr != `OFS_CMD
    && (pwrite || paddr > `OFS_COMP || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("bad access without error response");
  grounded_out_a: assert property (outputs_grounded == !display_enable)
    else $error("grounding does not follow display enable");
  osc_run_a: assert property (internal_osc_run == !oscillator_select)
    else $error("oscillator run does not follow select");
  pin_idle_a: assert property (!clock_output_enable |-> !clock_pin_out)
    else $error("clock pin toggles while not driven");
  inv_cmd_a: assert property (live && cmd_wr && (pwdata[7:0] & `CMD_INV_MASK) == `CMD_INV_VAL
    |=> inversion_select == $past(pwdata[1]))
    else $error("inversion command not applied");
  filt_cmd_a: assert property (live && cmd_wr && (pwdata[7:0] & `CMD_TFILT_MASK) == `CMD_TFILT_VAL
    |=> temp_filter_enable == $past(pwdata[0]))
    else $error("filter command not applied");
  fields_hold_a: assert property (!$past(cmd_wr) && !$past(cmd_wr, 2) |-> $stable({display_enable,
    mux_mode, bias_mode, write_bank_select, display_bank_select, inversion_select, temp_filter_enable,
    pump_enable, clock_output_enable}))
    else $error("configuration changed without a command");
  restart_dflt_a: assert property (serial_if_restart && !cmd_wr |=> !display_enable && mux_mode == 3'h4
    && !write_bank_select && !display_bank_select && temp_measure_enable && !pump_enable)
    else $error("restart without default configuration");
  line_inv_a: assert property (display_enable && !inversion_select && $changed(drive_polarity)
    |-> ##[1:LINE_CYCLES] ($changed(drive_polarity) || !display_enable || inversion_select))
    else $error("line inversion period too long");
  frame_inv_a: assert property (display_enable && inversion_select && $past(inversion_select)
    && mux_mode == 3'h4 && $changed(drive_polarity)
    |=> ($stable(drive_polarity) || !display_enable || !inversion_select) [*8])
    else $error("frame inversion toggles within a frame");
endmodule // lcd_cfg_asserts

bind lcd_driver_config_commands lcd_cfg_asserts #(.QUIET_CYCLES(QUIET_CYCLES), .LINE_CYCLES(LINE_CYCLES)) chk (.*);

// File: bench/tb_lcd_driver_config_commands.sv
// Self-checking bench for the display configuration command block.
`timescale 1ns/1ps
`include "lcd_cfg_map.vh"
module tb_lcd_driver_config_commands;
  localparam int QUIET = 20;
  localparam int TSAMP = 8;
  localparam logic [31:0] ST_DFLT = 32'h02060380;
  localparam logic [31:0] ST_MASK = 32'h07FFFFC0;
  logic mclk;
  logic rst;
  logic [7:0] sensor_code;
  wire psel, penable, pwrite, pready, pslverr;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  wire display_enable, outputs_grounded, write_bank_select, display_bank_select, inversion_select;
  wire drive_polarity, temp_measure_enable, temp_comp_enable, temp_filter_enable, pump_enable;
  wire pump_multiplier_cfg, oscillator_select, internal_osc_run, serial_if_restart;
  wire clock_pin_out, clock_output_enable;
  wire [2:0] mux_mode, slope_region_a, slope_region_b, slope_region_c, slope_region_d;
  wire [1:0] bias_mode;
  wire [5:0] data_pointer;
  wire [4:0] frame_freq;
  wire [7:0] programmed_voltage;
  int errors;
  int compares;
  logic [31:0] q;
  logic e;
  // The second byte misses the inversion pattern only in its fixed low bit, with the selector low.
  logic [7:0] cmds [13] = '{8'hD6, 8'hD5, 8'hD3, 8'hCF, 8'hC3, 8'hC5, 8'h0B, 8'h61, 8'h85, 8'h1F, 8'h22,
                            8'h4A, 8'h55};
  logic [7:0] tcode [3] = '{8'hFF, 8'h00, 8'h5A};

  lcd_driver_config_commands #(.QUIET_CYCLES(QUIET), .LINE_CYCLES(4), .TEMP_SAMPLE_CYCLES(TSAMP),
    .CLKOUT_HALF_CYCLES(3)) DUT (.*);
  host_model host (.*);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic init_seq;
    wr(`OFS_CMD, 32'h3A);
    wr(`OFS_CMD, 32'h3B);
  endtask

  task automatic chk_dflt;
    rd(`OFS_STATUS);
    check(q & ST_MASK, ST_DFLT);
    rd(`OFS_COMP);
    check(q, 32'h0);
    check(32'({outputs_grounded, internal_osc_run, clock_output_enable, serial_if_restart}), 32'hC);
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  initial begin
    errors = 0;
    compares = 0;
    rst = 1'b1;
    sensor_code = 8'h00;
    do_reset();
    chk_dflt();
    wr(`OFS_CMD, 32'hD3);
    rd(`OFS_STATUS);
    check(32'(q[`ST_TFE]), 32'h0);
    repeat (QUIET + 4) @(posedge mclk);
    rd(`OFS_STATUS);
    check(32'(q[`ST_READY]), 32'h1);
    init_seq();
    foreach (tcode[i]) begin
      sensor_code <= tcode[i];
      repeat (3 * TSAMP) @(posedge mclk);
      rd(`OFS_TEMP);
      check(q, 32'(tcode[i]));
    end
    wr(`OFS_CMD, 32'h80);
    wr(`OFS_CMD, 32'h39);
    repeat (30) @(posedge mclk);
    check(32'(outputs_grounded), 32'h0);
    foreach (cmds[i]) wr(`OFS_CMD, 32'(cmds[i]));
    repeat (40) @(posedge mclk);
    rd(`OFS_STATUS);
    check(q & 32'h07FFFFFF, 32'h063FF845);
    rd(`OFS_COMP);
    check(q, 32'h000017A5);
    check(32'(clock_output_enable), 32'h1);
    // With the filter on, a step of the sensor reaches the readout only gradually.
    sensor_code <= 8'hFF;
    repeat (2 * TSAMP) @(posedge mclk);
    rd(`OFS_TEMP);
    check(32'(q[7:0] == 8'hFF), 32'h0);
    repeat (50 * TSAMP) @(posedge mclk);
    rd(`OFS_TEMP);
    check(q, 32'hFF);
    rd(8'h10);
    check(32'(e), 32'h1);
    wr(`OFS_STATUS, 32'h0);
    check(32'(e), 32'h1);
    rd(`OFS_CMD);
    check(q, 32'h0);
    init_seq();
    repeat (4) @(posedge mclk);
    chk_dflt();
    wr(`OFS_CMD, 32'h39);
    wr(`OFS_CMD, 32'hD6);
    do_reset();
    chk_dflt();
    end_of_test();
  end
endmodule // tb_lcd_driver_config_commands
